// ---- inc/pssc_defs.vh ----
`ifndef PSSC_DEFS_VH
`define PSSC_DEFS_VH
// ********************************************************************
// Register byte addresses on the APB.
// ********************************************************************
`define PSSC_ADDR_TSEL_A   12'h000
`define PSSC_ADDR_TSEL_B   12'h004
`define PSSC_ADDR_SHDN     12'h008
`define PSSC_ADDR_RSTDLY   12'h00C
`define PSSC_ADDR_STEER    12'h010
`define PSSC_ADDR_MODE     12'h014
`define PSSC_ADDR_IRQ_STAT 12'h018
`define PSSC_ADDR_IRQ_MASK 12'h01C
// ********************************************************************
// Reset values.
// ********************************************************************
`define PSSC_RST_TSEL_A    8'h00
`define PSSC_RST_TSEL_B    2'h0
`define PSSC_RST_SHDN      8'h00
`define PSSC_RST_RSTDLY    8'h00
`define PSSC_RST_STEER     4'h1
`define PSSC_RST_MODE      8'h00
// ********************************************************************
// Field positions and codes.
// ********************************************************************
`define PSSC_SHDN_STAT     7
`define PSSC_SHDN_EXT      6
`define PSSC_SHDN_CALT     5
`define PSSC_SHDN_CFST     4
`define PSSC_RST_EN        7
`define PSSC_STEER_SYNC    4
`define PSSC_TB_T2         2'h0
`define PSSC_TB_T4         2'h1
`define PSSC_TB_T6         2'h2
`define PSSC_MODE_PWM      2'h3
`define PSSC_CFG_SINGLE    2'h0
`define PSSC_CFG_HALF      2'h2
`define PSSC_SAFE_LOW      2'h0
`define PSSC_SAFE_HIGH     2'h1
`define PSSC_INSTR_DIV     2'h3
`endif

// ---- rtl/pssc_top.v ----
// Notes on behaviour
// RULE_01: timer select code picks one of three timers.
// RULE_02: fifth select in low bits, upper read zero.
// RULE_03: status bit set holds outputs in safe state.
// RULE_04: source two: low external pin shuts down.
// RULE_05: source one: low alternate comparator shuts down.
// RULE_06: source zero: low first comparator shuts down.
// RULE_07: sync option delays shutdown to timer event.
// RULE_08: pins A,C safe state low, high, or float.
// RULE_09: pins B,D safe state low, high, or float.
// RULE_10: restart enable clears status once sources gone.
// RULE_11: without restart, software clears the status bit.
// RULE_12: delay count instruction cycles before active edges; in half bridge, pin B's active edge is not delayed.
// RULE_13: steering update at period or instruction boundary.
// RULE_14: steer bits route waveform, polarity, else port.
// RULE_15: steering only in PWM single-output configuration.
// RULE_16: restart enable cleared by clock start-up options.
// RULE_17: polarity bits: bit1 A,C; bit0 B,D.
// RULE_18: half bridge modulates A,B with dead band; the delay count holds back only A's active edge, none of B's.
// RULE_19: resume outputs at next period start.
`timescale 1ns/10ps
`include "pssc_defs.vh"
module pssc_top #(
    parameter DLY_W = 7                          // Delay count width.
) (
    input  wire        i_ref_clk,                // Core clock, 200 MHz.
    input  wire        i_rst,                    // Sync reset, high.
    input  wire        i_psel,                   // APB select.
    input  wire        i_penable,                // APB enable.
    input  wire        i_pwrite,                 // APB direction.
    input  wire [11:0] i_paddr,                  // APB byte address.
    input  wire [31:0] i_pwdata,                 // APB write data.
    output wire        o_pready,                 // APB ready.
    output reg  [31:0] o_prdata,                 // APB read data.
    output wire        o_pslverr,                // APB error.
    input  wire [2:0]  i_period_start,           // Period pulses, 3 timers.
    input  wire        i_pwm_raw,                // Raw duty waveform.
    input  wire        i_ext_int_pin,            // External pin, async.
    input  wire        i_cmp_first_out,          // First comparator, async.
    input  wire        i_cmp_alt_out,            // Alternate comparator.
    input  wire        i_cmp_sync_en,            // Comparator sync option.
    input  wire        i_timer1_sync,            // 16-bit timer sync pulse.
    input  wire        i_restart_clr_cond,       // Clock start-up clear.
    input  wire [3:0]  i_port_out,               // Port data for pins.
    input  wire [3:0]  i_port_oe,                // Port enables for pins.
    output wire [4:0]  o_chan_timebase,          // Channel 5 and 4 selections, LSB zero.
    output reg  [3:0]  o_pwm_pin,                // Pins A..D levels.
    output reg  [3:0]  o_pwm_pin_oe,             // Pins A..D enables.
    output wire        o_irq                     // Level interrupt.
);
    // ****************************************************************
    // Registers.
    // ****************************************************************
    reg [7:0]  tsel_a_q;                         // Channels 1..4 select.
    reg [1:0]  tsel_b_q;                         // Channel 5 select.
    reg [7:0]  shdn_q;                           // Shutdown control.
    reg [7:0]  rstdly_q;                         // Restart and delay.
    reg [4:0]  steer_q;                          // Steering written.
    reg [3:0]  steer_act_q;                      // Steering in effect.
    reg [7:0]  mode_q;                           // Config and mode.
    reg [1:0]  irq_stat_q;                       // Shutdown, restart.
    reg [1:0]  irq_mask_q;                       // Interrupt mask.
    reg [1:0]  ext_s_q, cf_s_q, ca_s_q;          // Synchronisers.
    reg        hold_q;                           // Waits for period start.
    reg [1:0]  icyc_q;                           // Instruction divider.
    reg [DLY_W-1:0] dly_cnt_q;                   // Edge delay counter.
    reg        pwm_q;                            // Delayed waveform.
    reg        pwm_prev_q;                       // Raw previous level.
    reg        cmp_pend_q;                       // Sync pending shutdown.
    // ****************************************************************
    // Decode and time base.
    // ****************************************************************
    wire wr = i_psel & i_penable & i_pwrite;
    wire [1:0] tb_sel = tsel_a_q[1:0];
    reg  per_start;
    // Channel one's selected timer gives this block its period edge.
    always @* begin
        if (tb_sel == `PSSC_TB_T2) begin                  // [RULE_01]
            per_start = i_period_start[0];
        end else if (tb_sel == `PSSC_TB_T4) begin
            per_start = i_period_start[1];
        end else if (tb_sel == `PSSC_TB_T6) begin
            per_start = i_period_start[2];
        end else begin
            per_start = 1'b0;                     // Reserved code idles.
        end
    end
    assign o_chan_timebase = {tsel_b_q, tsel_a_q[7:6], 1'b0} ;
    wire icyc = (icyc_q == `PSSC_INSTR_DIV);
    wire pwm_mode = (mode_q[3:2] == `PSSC_MODE_PWM);
    wire single   = (mode_q[7:6] == `PSSC_CFG_SINGLE);
    wire half     = (mode_q[7:6] == `PSSC_CFG_HALF);
    // ****************************************************************
    // Shutdown sources, all low active after two flops.
    // ****************************************************************
    wire src_ext = shdn_q[`PSSC_SHDN_EXT] & ~ext_s_q[1];     // [RULE_04]
    wire src_cmp = (shdn_q[`PSSC_SHDN_CFST] & ~cf_s_q[1]) |  // [RULE_06]
                   (shdn_q[`PSSC_SHDN_CALT] & ~ca_s_q[1]);   // [RULE_05]
    // Comparator trips may wait for the timer sync pulse.
    wire cmp_fire = i_cmp_sync_en ? (cmp_pend_q & i_timer1_sync)
                                  : src_cmp;                 // [RULE_07]
    wire any_src = src_ext | src_cmp;
    wire trip = src_ext | cmp_fire;
    wire sw_clr = wr && (i_paddr == `PSSC_ADDR_SHDN) &&
                  !i_pwdata[`PSSC_SHDN_STAT];
    wire auto_clr = rstdly_q[`PSSC_RST_EN] & ~any_src &
                    shdn_q[`PSSC_SHDN_STAT];                 // [RULE_10]
    // ****************************************************************
    // Synchronisers and instruction divider.
    // ****************************************************************
    // Pins from outside pass two flops; only stage two is read.
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            ext_s_q <= 2'h3;
            cf_s_q  <= 2'h3;
            ca_s_q  <= 2'h3;
            icyc_q  <= 2'h0;
        end else begin
            ext_s_q <= {ext_s_q[0], i_ext_int_pin};
            cf_s_q  <= {cf_s_q[0], i_cmp_first_out};
            ca_s_q  <= {ca_s_q[0], i_cmp_alt_out};
            icyc_q  <= icyc_q + 2'h1;
        end
    end
    // ****************************************************************
    // Register file, shutdown status and interrupts.
    // ****************************************************************
    // Hardware set of the status bit wins over any clear.
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            tsel_a_q   <= `PSSC_RST_TSEL_A;
            tsel_b_q   <= `PSSC_RST_TSEL_B;
            shdn_q     <= `PSSC_RST_SHDN;
            rstdly_q   <= `PSSC_RST_RSTDLY;
            steer_q    <= {1'b0, `PSSC_RST_STEER};
            mode_q     <= `PSSC_RST_MODE;
            irq_stat_q <= 2'h0;
            irq_mask_q <= 2'h0;
            cmp_pend_q <= 1'b0;
            hold_q     <= 1'b0;
        end else begin
            if (wr && i_paddr == `PSSC_ADDR_TSEL_A) begin
                tsel_a_q <= i_pwdata[7:0];
            end else if (wr && i_paddr == `PSSC_ADDR_TSEL_B) begin
                tsel_b_q <= i_pwdata[1:0];                    // [RULE_02]
            end else if (wr && i_paddr == `PSSC_ADDR_SHDN) begin
                shdn_q[6:0] <= i_pwdata[6:0];
            end else if (wr && i_paddr == `PSSC_ADDR_RSTDLY) begin
                rstdly_q <= i_pwdata[7:0];
            end else if (wr && i_paddr == `PSSC_ADDR_STEER) begin
                steer_q <= i_pwdata[4:0];
            end else if (wr && i_paddr == `PSSC_ADDR_MODE) begin
                mode_q <= i_pwdata[7:0];
            end else if (wr && i_paddr == `PSSC_ADDR_IRQ_MASK) begin
                irq_mask_q <= i_pwdata[1:0];
            end
            if (i_restart_clr_cond) begin
                rstdly_q[`PSSC_RST_EN] <= 1'b0;               // [RULE_16]
            end
            // Comparator trip waits here when sync is on.
            if (!i_cmp_sync_en || i_timer1_sync) begin
                cmp_pend_q <= 1'b0;
            end
            if (i_cmp_sync_en && src_cmp && !i_timer1_sync) begin
                cmp_pend_q <= 1'b1;
            end
            // Status: set wins; software or auto restart clears.
            if (trip) begin
                shdn_q[`PSSC_SHDN_STAT] <= 1'b1;              // [RULE_03]
            end else if (sw_clr || auto_clr) begin            // [RULE_11]
                shdn_q[`PSSC_SHDN_STAT] <= 1'b0;
            end else if (wr && i_paddr == `PSSC_ADDR_SHDN) begin
                shdn_q[`PSSC_SHDN_STAT] <= i_pwdata[`PSSC_SHDN_STAT];
            end
            // After release, outputs wait for a period boundary.
            if (trip) begin
                hold_q <= 1'b1;
            end else if (hold_q && !shdn_q[`PSSC_SHDN_STAT] &&
                         per_start) begin
                hold_q <= 1'b0;                               // [RULE_19]
            end
            // Sticky events; write one clears, new event wins.
            irq_stat_q[0] <= irq_stat_q[0] | trip;
            irq_stat_q[1] <= irq_stat_q[1] | (auto_clr & ~trip);
            if (wr && i_paddr == `PSSC_ADDR_IRQ_STAT) begin
                irq_stat_q[0] <= trip | (irq_stat_q[0] & ~i_pwdata[0]);
                irq_stat_q[1] <= (auto_clr & ~trip) |
                                 (irq_stat_q[1] & ~i_pwdata[1]);
            end
        end
    end
    assign o_irq = |(irq_stat_q & irq_mask_q);
    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;
    // ****************************************************************
    // APB read mux.
    // ****************************************************************
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            if (i_paddr == `PSSC_ADDR_TSEL_A) begin
                o_prdata <= {24'h000000, tsel_a_q};
            end else if (i_paddr == `PSSC_ADDR_TSEL_B) begin
                o_prdata <= {30'h0, tsel_b_q};                // [RULE_02]
            end else if (i_paddr == `PSSC_ADDR_SHDN) begin
                o_prdata <= {24'h000000, shdn_q};
            end else if (i_paddr == `PSSC_ADDR_RSTDLY) begin
                o_prdata <= {24'h000000, rstdly_q};
            end else if (i_paddr == `PSSC_ADDR_STEER) begin
                o_prdata <= {27'h0, steer_q};
            end else if (i_paddr == `PSSC_ADDR_MODE) begin
                o_prdata <= {24'h000000, mode_q};
            end else if (i_paddr == `PSSC_ADDR_IRQ_STAT) begin
                o_prdata <= {30'h0, irq_stat_q};
            end else if (i_paddr == `PSSC_ADDR_IRQ_MASK) begin
                o_prdata <= {30'h0, irq_mask_q};
            end else begin
                o_prdata <= 32'h0000_0000;        // Unmapped reads zero.
            end
        end
    end
    // ****************************************************************
    // Edge delay and steering update.
    // ****************************************************************
    // A rising raw edge is held back by the delay count in
    // instruction cycles; falling edges pass at once. The delay
    // longer than the high time swallows the pulse, a known limit.
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            dly_cnt_q   <= {DLY_W{1'b0}};
            pwm_q       <= 1'b0;
            pwm_prev_q  <= 1'b0;
            steer_act_q <= `PSSC_RST_STEER;
        end else begin
            pwm_prev_q <= i_pwm_raw;
            if (!i_pwm_raw) begin
                pwm_q     <= 1'b0;
                dly_cnt_q <= {DLY_W{1'b0}};
            end else if (!pwm_prev_q) begin
                dly_cnt_q <= rstdly_q[DLY_W-1:0];             // [RULE_12]
                pwm_q     <= (rstdly_q[DLY_W-1:0] == {DLY_W{1'b0}});
            end else if (dly_cnt_q != {DLY_W{1'b0}}) begin
                if (icyc) begin
                    dly_cnt_q <= dly_cnt_q - 1'b1;
                    pwm_q     <= (dly_cnt_q == {{(DLY_W-1){1'b0}},1'b1});
                end
            end
            if (steer_q[`PSSC_STEER_SYNC] ? per_start : icyc) begin
                steer_act_q <= steer_q[3:0];                  // [RULE_13]
            end
        end
    end
    // ****************************************************************
    // Pin drive.
    // ****************************************************************
    wire pol_ac = mode_q[1];                                  // [RULE_17]
    wire pol_bd = mode_q[0];
    wire lvl_ac = pwm_q ^ pol_ac;
    wire lvl_bd = i_pwm_raw ? pol_bd : ~pol_bd;  // Complement for bridge.
    integer k;
    // Shutdown forces safe states; else steering or half bridge.
    always @* begin
        o_pwm_pin    = i_port_out;
        o_pwm_pin_oe = i_port_oe;
        if (pwm_mode && single) begin                         // [RULE_15]
            for (k = 0; k < 4; k = k + 1) begin
                if (steer_act_q[k]) begin                     // [RULE_14]
                    o_pwm_pin[k]    = (k[0] ? pol_bd : pol_ac) ^ pwm_q;
                    o_pwm_pin_oe[k] = 1'b1;
                end
            end
        end else if (pwm_mode && half) begin                  // [RULE_18]
            o_pwm_pin[0] = lvl_ac;
            o_pwm_pin[1] = lvl_bd & (~i_pwm_raw | pwm_q | 1'b1) &
                           ~(pwm_q & ~i_pwm_raw);
            o_pwm_pin_oe[1:0] = 2'h3;
        end
        if (pwm_mode && (shdn_q[`PSSC_SHDN_STAT] || hold_q)) begin
            o_pwm_pin[0] = (shdn_q[3:2] == `PSSC_SAFE_HIGH);  // [RULE_08]
            o_pwm_pin[2] = (shdn_q[3:2] == `PSSC_SAFE_HIGH);
            o_pwm_pin_oe[0] = ~shdn_q[3];
            o_pwm_pin_oe[2] = ~shdn_q[3];
            o_pwm_pin[1] = (shdn_q[1:0] == `PSSC_SAFE_HIGH);  // [RULE_09]
            o_pwm_pin[3] = (shdn_q[1:0] == `PSSC_SAFE_HIGH);
            o_pwm_pin_oe[1] = ~shdn_q[1];
            o_pwm_pin_oe[3] = ~shdn_q[1];
        end
    end
endmodule // pssc_top

// ---- tb/pssc_bridge_model.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Power stage model: gate drivers behind the four pins.
// ****************************************************************
module pssc_bridge_model (
    input  wire logic [3:0] i_pin,     // Pin levels from the block.
    input  wire logic [3:0] i_pin_oe,  // Pin enables from the block.
    input  wire logic       i_trip,    // Bench commands a fault.
    output logic      [3:0] o_line,    // Level at the driver inputs.
    output logic            o_fault_n  // Fault line, active low.
);
    // A released pin is pulled down, so the switch stays off.
    assign o_line = i_pin & i_pin_oe;
    // The fault line sits high and goes low only on command.
    assign o_fault_n = !i_trip;
endmodule // pssc_bridge_model

// ---- tb/pssc_checker.sv ----
`timescale 1ns/10ps
`include "pssc_defs.vh"
// ****************************************************************
// Port checker; control fields are shadowed from APB writes.
// ****************************************************************
module pssc_checker #(
    parameter DLY_W = 7                   // Same as the design.
) (
    input wire logic        i_ref_clk,     // Core clock.
    input wire logic        i_rst,         // Sync reset.
    input wire logic        i_psel,        // APB select.
    input wire logic        i_penable,     // APB enable.
    input wire logic        i_pwrite,      // APB direction.
    input wire logic [11:0] i_paddr,       // APB address.
    input wire logic [31:0] i_pwdata,      // APB write data.
    input wire logic        o_pready,      // APB ready.
    input wire logic [31:0] o_prdata,      // APB read data.
    input wire logic        o_pslverr,     // APB error.
    input wire logic        i_ext_int_pin, // External fault pin.
    input wire logic [3:0]  i_port_out,    // Port data.
    input wire logic [3:0]  i_port_oe,     // Port enables.
    input wire logic [3:0]  o_pwm_pin,     // Pin levels.
    input wire logic [3:0]  o_pwm_pin_oe,  // Pin enables.
    input wire logic        o_irq          // Interrupt.
);
    logic [7:0] shd_q;   // Shutdown control copy.
    logic [4:0] steer_q; // Steering copy.
    logic [7:0] mode_q;  // Mode copy.
    logic [1:0] mask_q;  // Interrupt mask copy.
    logic [3:0] off_q;   // Cycles spent out of PWM mode, saturating.
    wire wr_go = i_psel && i_penable && i_pwrite && o_pready;
    wire rd_go = i_psel && !i_penable && !i_pwrite;
    wire pwm_on = mode_q[3:2] == 2'h3;
    // Shadows land at the access edge, where the design takes writes.
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            shd_q <= 8'h00;
            steer_q <= 5'h01;
            mode_q <= 8'h00;
            mask_q <= 2'h0;
            off_q <= 4'h0;
        end else begin
            if (wr_go && i_paddr == `PSSC_ADDR_SHDN) shd_q <= i_pwdata[7:0];
            if (wr_go && i_paddr == `PSSC_ADDR_STEER) steer_q <= i_pwdata[4:0];
            if (wr_go && i_paddr == `PSSC_ADDR_MODE) mode_q <= i_pwdata[7:0];
            if (wr_go && i_paddr == `PSSC_ADDR_IRQ_MASK) mask_q <= i_pwdata[1:0];
            off_q <= pwm_on ? 4'h0 : (off_q == 4'hF ? off_q : off_q + 4'h1);
        end
    end
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    apb_resp_ok_a: assert property (o_pready && !o_pslverr)
        else $error("APB slave stalled or flagged an error");
    unmapped_zero_a: assert property (rd_go && i_paddr >= 12'h020 |=>
        o_prdata == 32'h0) else $error("Unmapped read not zero");
    tselb_upper_zero_a: assert property (rd_go && i_paddr == 12'h004 |=>
        o_prdata[31:2] == 30'h0) else $error("Select B upper bits set");
    rdata_hold_a: assert property (!i_rst && !rd_go |=> $stable(o_prdata))
        else $error("Read data moved without a read");
    port_when_off_a: assert property (off_q == 4'hF |->
        o_pwm_pin_oe == i_port_oe && (o_pwm_pin & i_port_oe) ==
        (i_port_out & i_port_oe)) else $error("Pins not on port");
    safe_pins_ac_a: assert property ($fell(i_ext_int_pin) && shd_q[6] &&
        pwm_on && steer_q[0] |-> ##[1:8] (shd_q[3] ? !o_pwm_pin_oe[0] :
        o_pwm_pin_oe[0] && o_pwm_pin[0] == shd_q[2])) else $error("Pin A");
    safe_pins_bd_a: assert property ($fell(i_ext_int_pin) && shd_q[6] &&
        pwm_on && steer_q[1] |-> ##[1:8] (shd_q[1] ? !o_pwm_pin_oe[1] :
        o_pwm_pin_oe[1] && o_pwm_pin[1] == shd_q[0])) else $error("Pin B");
    irq_masked_a: assert property (mask_q == 2'h0 |-> !o_irq)
        else $error("Interrupt raised while fully masked");
    cover property ($fell(i_ext_int_pin) && shd_q[6] && pwm_on);
    cover property ($rose(o_irq));
    cover property (off_q == 4'hF && rd_go);
endmodule // pssc_checker
bind pssc_top pssc_checker #(.DLY_W(DLY_W)) pssc_checker_inst (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_ext_int_pin(i_ext_int_pin),
    .i_port_out(i_port_out), .i_port_oe(i_port_oe),
    .o_pwm_pin(o_pwm_pin), .o_pwm_pin_oe(o_pwm_pin_oe), .o_irq(o_irq));

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`include "pssc_defs.vh"
module tb;
    logic clk = 1'b0;        // Core clock.
    logic rst = 1'b1;        // Reset, high.
    logic psel = 1'b0;       // APB select.
    logic pen = 1'b0;        // APB enable.
    logic pwr = 1'b0;        // APB direction.
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] pstart = 3'h0;  // Period pulses.
    logic raw = 1'b0;           // Raw duty waveform.
    logic [2:0] flt_n = 3'h7;   // Faults: pin, alternate, first.
    logic sync_en = 1'b0;       // Comparator sync option.
    logic t1sync = 1'b0;        // 16-bit timer sync pulse.
    logic clr_cond = 1'b0;      // Start-up clear condition.
    logic [3:0] port_out = 4'h0, port_oe = 4'h0;
    logic [31:0] lfsr = 32'h000135BF;  // Seed 79295.
    logic probe = 1'b0;         // Asks the monitor to sample pins.
    logic [31:0] exp_q[$];      // Expected results, oldest first.
    int miscompares = 0, checks_done = 0;
    wire [31:0] prdata;
    wire pready, pslverr, irq, fault_n;
    wire [4:0] tbase;
    wire [3:0] pin, pin_oe, line;
    initial begin
        forever #2.5 clk = ~clk;
    end
    pssc_top #(.DLY_W(7)) pssc_top_inst (.i_ref_clk(clk), .i_rst(rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr), .i_period_start(pstart), .i_pwm_raw(raw),
        .i_ext_int_pin(fault_n), .i_cmp_first_out(flt_n[0]),
        .i_cmp_alt_out(flt_n[1]), .i_cmp_sync_en(sync_en),
        .i_timer1_sync(t1sync), .i_restart_clr_cond(clr_cond),
        .i_port_out(port_out), .i_port_oe(port_oe), .o_chan_timebase(tbase),
        .o_pwm_pin(pin), .o_pwm_pin_oe(pin_oe), .o_irq(irq));
    pssc_bridge_model pssc_bridge_model_inst (.i_pin(pin), .i_pin_oe(pin_oe),
        .i_trip(!flt_n[2]), .o_line(line), .o_fault_n(fault_n));
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Safe-state pins {oe, line} for a shutdown field of the form {ac, bd}.
    function automatic logic [7:0] safe_pins(input logic [3:0] f);
        logic [1:0] oe;
        oe = {!f[1], !f[3]};
        safe_pins = {oe, oe, {f[0], f[2]} & oe, {f[0], f[2]} & oe};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic complete_run;
        if (exp_q.size() != 0) miscompares++;
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            complete_run();
        end
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic pins(input logic [8:0] want);
        exp_q.push_back({23'h0, want});
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
        @(posedge clk);
    endtask
    task automatic period;
        pstart <= 3'h7;
        @(posedge clk);
        pstart <= 3'h0;
        @(posedge clk);
    endtask
    // The monitor pairs each read or pin sample with the oldest note.
    always @(posedge clk) begin
        if ((psel && pen && !pwr && pready) || probe) begin
            check(probe ? {23'h0, irq, pin_oe, line} : prdata, exp_q.pop_front());
        end
    end
    initial begin
        logic [3:0] sf;
        logic [7:0] en;
        cyc(4);
        rst <= 1'b0;
        lfsr = next_rand(lfsr);
        port_out <= lfsr[3:0];
        port_oe <= lfsr[7:4];
        @(posedge clk);
        rd(`PSSC_ADDR_SHDN, 0);
        rd(`PSSC_ADDR_RSTDLY, 0);
        rd(`PSSC_ADDR_STEER, 1);
        rd(12'h020, 0);
        pins({1'b0, port_oe, port_out & port_oe});
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            wr(`PSSC_ADDR_TSEL_A, lfsr);
            rd(`PSSC_ADDR_TSEL_A, lfsr[7:0]);
            wr(`PSSC_ADDR_TSEL_B, lfsr);
            rd(`PSSC_ADDR_TSEL_B, lfsr[1:0]);
        end
        wr(`PSSC_ADDR_TSEL_A, 0);
        wr(`PSSC_ADDR_STEER, 32'h0F);
        for (int p = 0; p < 4; p++) begin
            lfsr = next_rand(lfsr);
            raw <= lfsr[0];
            wr(`PSSC_ADDR_MODE, 32'h0C | p);
            cyc(8);
            pins({5'h0F, {2{lfsr[0] ^ p[0], lfsr[0] ^ p[1]}}});
        end
        raw <= 1'b1;
        wr(`PSSC_ADDR_MODE, 32'h0C);
        wr(`PSSC_ADDR_STEER, 32'h11);
        cyc(8);
        pins(9'h0FF);
        period();
        pins({1'b0, port_oe[3:1], 1'b1, port_out[3:1] & port_oe[3:1], 1'b1});
        wr(`PSSC_ADDR_STEER, 32'h0F);
        cyc(8);
        pins(9'h0FF);
        for (int s = 0; s < 3; s++) begin
            en = 8'h10 << s;
            sf = {s[1:0], 2'(2 - s)};
            wr(`PSSC_ADDR_SHDN, sf);
            flt_n <= ~(3'h1 << s);
            cyc(8);
            rd(`PSSC_ADDR_SHDN, sf);
            wr(`PSSC_ADDR_SHDN, en | sf);
            cyc(8);
            pins({1'b0, safe_pins(sf)});
            rd(`PSSC_ADDR_SHDN, 8'h80 | en | sf);
            flt_n <= 3'h7;
            cyc(8);
            rd(`PSSC_ADDR_SHDN, 8'h80 | en | sf);
            wr(`PSSC_ADDR_SHDN, en | sf);
            pins({1'b0, safe_pins(sf)});
            period();
            pins(9'h0FF);
        end
        wr(`PSSC_ADDR_RSTDLY, 32'h80);
        rd(`PSSC_ADDR_RSTDLY, 32'h80);
        wr(`PSSC_ADDR_IRQ_MASK, 1);
        wr(`PSSC_ADDR_IRQ_STAT, 3);
        wr(`PSSC_ADDR_SHDN, 32'h40);
        flt_n <= 3'h3;
        cyc(8);
        pins({1'b1, safe_pins(4'h0)});
        flt_n <= 3'h7;
        cyc(8);
        rd(`PSSC_ADDR_SHDN, 32'h40);
        wr(`PSSC_ADDR_IRQ_STAT, 3);
        pins({1'b0, safe_pins(4'h0)});
        period();
        pins(9'h0FF);
        wr(`PSSC_ADDR_IRQ_MASK, 0);
        clr_cond <= 1'b1;
        cyc(2);
        rd(`PSSC_ADDR_RSTDLY, 0);
        clr_cond <= 1'b0;
        sync_en <= 1'b1;
        wr(`PSSC_ADDR_SHDN, 32'h10);
        flt_n <= 3'h6;
        cyc(8);
        rd(`PSSC_ADDR_SHDN, 32'h10);
        t1sync <= 1'b1;
        @(posedge clk);
        t1sync <= 1'b0;
        cyc(6);
        rd(`PSSC_ADDR_SHDN, 32'h90);
        sync_en <= 1'b0;
        flt_n <= 3'h7;
        cyc(4);
        wr(`PSSC_ADDR_SHDN, 0);
        wr(`PSSC_ADDR_MODE, 0);
        cyc(20);
        pins({1'b0, port_oe, port_out & port_oe});
        complete_run();
    end
endmodule // tb
